// file: rtl/dee_device.sv
// data eeprom with row latch, timed programming cycle, readout protection and a sticky write/erase protect option bit that gates no access
`timescale 1ns/1ps
`default_nettype none
module dee_device
  import dee_pkg::*;
#(
  parameter int PROG_CYC = DEE_PROG_CYC  // programming cycle length in clocks
) (
  // clock and reset
  input  wire logic REF_CLK,
  input  wire logic ARST_N,
  // memory bus
  dee_bus_if.dev    BUS,
  // option strap
  input  wire logic [1:0] OPTION_INIT,
  // status
  output logic            BUSY,
  output logic            ERASING
);
  // sizes derived from the window and the cycle length
  localparam int N  = 1 << DEE_AREA_AW;       // cells in the window
  localparam int CW = $clog2(PROG_CYC + 1);   // cycle timer width

  // storage
  logic [7:0]               cell_r  [N];             // eeprom cells, kept across resets
  logic [7:0]               latch_r [DEE_ROW_BYTES]; // row latch data, never readable
  logic [DEE_ROW_BYTES-1:0] lv_r;                    // latch valid flags
  logic [DEE_AREA_AW-6:0]   row_r;                   // row of the last latched write

  // control register
  logic                     lwm_r;                   // latch_write_mode
  logic                     go_r;                    // program_cycle_go
  logic [CW-1:0]            cnt_r;                   // cycle timer

  // option strap synchroniser
  logic [1:0]               option_s1_r;             // first stage, read by the second only
  logic [1:0]               option_s2_r;             // second stage
  logic [1:0]               option_s3_r;             // third stage
  logic [1:0]               strap_cnt_r;             // settling count after release
  logic                     strap_r;                 // option strap taken

  // options and flash register
  logic [1:0]               option_r;                // readout and write/erase options
  logic [1:0]               key_r;                   // unlock progress
  logic [7:0]               flash_r;                 // flash_control_status
  logic                     erase_r;                 // one-cycle erase pulse

  // power and bus answer
  logic                     wait_r;                  // in wait state
  logic                     ack_r;                   // one-cycle answer
  logic                     drv_r;                   // read data driven
  logic [7:0]               rd_r;                    // read data

  // address decode, one access per request
  wire       in_area    = BUS.req && !ack_r &&
                          BUS.addr[15:DEE_AREA_AW] == DEE_AREA_BASE[15:DEE_AREA_AW];
  wire       hit_csr    = BUS.req && !ack_r && BUS.addr == DEE_CTRL_ADDR;
  wire       hit_flash  = BUS.req && !ack_r && BUS.addr == DEE_FLASH_ADDR;
  wire       hit_option = BUS.req && !ack_r && BUS.addr == DEE_OPTION_ADDR;
  wire       wr         = BUS.we;                    // write access
  wire [4:0] col        = BUS.addr[4:0];             // column inside the row

  // cycle control
  wire done    = go_r && cnt_r == CW'(PROG_CYC - 1);
  wire stop    = BUS.halt;
  wire rdp     = option_r[DEE_RDP_BIT];
  // a wait request holds off only while idle; a running cycle finishes first
  wire to_wait = BUS.wait_req && !go_r;

  // software writes to the control register
  wire csr_wr   = hit_csr && wr && !done && !stop;   // cycle end wins over a write
  wire lwm_set  = csr_wr && BUS.wdata[DEE_LATCH_BIT];
  wire lwm_clr  = csr_wr && !BUS.wdata[DEE_LATCH_BIT] && !go_r;
  wire go_set   = csr_wr && BUS.wdata[DEE_GO_BIT] && lwm_r && !wait_r;

  // latch handling
  wire latch_clr  = done ||
                    (hit_csr && wr && !BUS.wdata[DEE_LATCH_BIT] && !go_r);
  wire latch_take = in_area && wr && lwm_r && !rdp && !latch_clr;
  // a second write to one column ands into the held byte
  wire [7:0] latch_and = lv_r[col] ? (latch_r[col] & BUS.wdata) : BUS.wdata;

  // read sources; latch data has no path onto the bus
  wire [7:0] csr     = {6'h00, lwm_r, go_r};
  wire [7:0] area_rd = rdp ? DEE_ERASED : cell_r[BUS.addr[DEE_AREA_AW-1:0]];
  wire [7:0] rd_nxt  = in_area    ? area_rd :
                       hit_csr    ? csr :
                       hit_flash  ? flash_r :
                       hit_option ? {6'h00, option_r} :
                       8'h00;                        // unmapped reads give zero
  wire       drv_nxt = BUS.req && !ack_r && !wr && !(in_area && lwm_r);
  wire       ack_nxt = BUS.req && !ack_r;            // every request answered once

  // option strap settling
  wire strap_ok = !strap_r && strap_cnt_r == 2'd3 && option_s2_r == option_s3_r;

  // control register and cycle timer
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      // a reset in mid cycle leaves the row unwritten; cells change only when the cycle completes or on the erase pulse
      lwm_r <= 1'b0;
      go_r  <= 1'b0;
      cnt_r <= '0;
    end else if (stop) begin
      // halt drops the cycle at once; the latch bit stays
      go_r  <= 1'b0;
      cnt_r <= '0;
    end else if (done) begin
      go_r  <= 1'b0;
      lwm_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      if (go_r)
        cnt_r <= cnt_r + 1'b1;
      if (lwm_set)
        lwm_r <= 1'b1;
      else if (lwm_clr)
        lwm_r <= 1'b0;
      if (go_set)
        go_r <= 1'b1;
    end
  end

  // wait state: held while the request stands
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= to_wait || (wait_r && BUS.wait_req);
    end
  end

  // latch valid flags and target row
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lv_r  <= '0;
      row_r <= '0;
    end else if (latch_clr) begin
      lv_r  <= '0;
    end else if (latch_take) begin
      lv_r[col] <= 1'b1;
      row_r     <= BUS.addr[DEE_AREA_AW-1:5];
    end
  end

  // latch data and cells carry no reset: the cells are the nonvolatile store
  always_ff @(posedge REF_CLK) begin
    if (latch_take)
      latch_r[col] <= latch_and;
    if (done) begin
      // programming only clears bits; erase is the only way back to ones
      for (int i = 0; i < DEE_ROW_BYTES; i++) begin
        if (lv_r[i])
          cell_r[{row_r, 5'(i)}] <= cell_r[{row_r, 5'(i)}] & latch_r[i];
      end
    end
    if (erase_r) begin
      for (int j = 0; j < N; j++)
        cell_r[j] <= DEE_ERASED;
    end
  end

  // option strap passes three stages before it is taken
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      option_s1_r <= 2'b00;
      option_s2_r <= 2'b00;
      option_s3_r <= 2'b00;
    end else begin
      option_s1_r <= OPTION_INIT;
      option_s2_r <= option_s1_r;
      option_s3_r <= option_s2_r;
    end
  end

  // options: strap first, then software; write/erase protect is sticky
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      option_r    <= 2'b00;
      strap_cnt_r <= 2'b00;
      strap_r     <= 1'b0;
      erase_r     <= 1'b0;
    end else begin
      erase_r <= 1'b0;
      if (!strap_r && strap_cnt_r != 2'd3)
        strap_cnt_r <= strap_cnt_r + 2'd1;
      if (strap_ok) begin
        option_r <= option_s3_r;
        strap_r  <= 1'b1;
      end else if (strap_r && hit_option && wr) begin
        // removing readout protection wipes the window one clock after the bit clears
        if (rdp && !BUS.wdata[DEE_RDP_BIT])
          erase_r <= 1'b1;
        option_r[DEE_RDP_BIT] <= BUS.wdata[DEE_RDP_BIT];
        option_r[DEE_WEP_BIT] <= option_r[DEE_WEP_BIT] | BUS.wdata[DEE_WEP_BIT];
      end
    end
  end

  // flash register opens only after the two keys in order
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      key_r   <= 2'b00;
      flash_r <= DEE_CSR_RST;
    end else if (hit_flash && wr) begin
      if (key_r == 2'd2)
        flash_r <= {5'h00, BUS.wdata[2:0]};
      else if (key_r == 2'd0 && BUS.wdata == DEE_KEY1)
        key_r <= 2'd1;
      else if (key_r == 2'd1 && BUS.wdata == DEE_KEY2)
        key_r <= 2'd2;
      else
        key_r <= 2'd0;                               // wrong key restarts the sequence
    end
  end

  // bus answer: one cycle after the request is seen
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_r <= 1'b0;
      drv_r <= 1'b0;
      rd_r  <= 8'h00;
    end else begin
      ack_r <= ack_nxt;
      drv_r <= drv_nxt;
      rd_r  <= rd_nxt;
    end
  end

  // outputs straight from registers
  assign BUS.ack     = ack_r;
  assign BUS.rdata   = rd_r;
  assign BUS.rdrive  = drv_r;
  assign BUS.waiting = wait_r;
  assign BUSY        = go_r;
  assign ERASING     = erase_r;
endmodule : dee_device
`default_nettype wire

// file: rtl/dee_pkg.sv
// package: data eeprom row programmer constants, register map and behaviour notes
package dee_pkg;
  // register offsets on the memory bus (byte addresses)
  localparam logic [15:0] DEE_CTRL_ADDR    = 16'h0030; // eeprom_control_status
  localparam logic [15:0] DEE_FLASH_ADDR   = 16'h0031; // flash_control_status
  localparam logic [15:0] DEE_OPTION_ADDR  = 16'h0032; // option bits
  localparam logic [15:0] DEE_AREA_BASE    = 16'h1000; // eeprom window base
  localparam int          DEE_AREA_AW      = 7;        // 128 bytes = 4 rows
  // control bit positions
  localparam int DEE_GO_BIT  = 0;
  localparam int DEE_LATCH_BIT = 1;
  localparam int DEE_RDP_BIT = 0;  // readout_protect_option
  localparam int DEE_WEP_BIT = 1;  // write_erase_protect_option
  localparam logic [7:0] DEE_CSR_RST  = 8'h00;
  localparam logic [7:0] DEE_KEY1     = 8'h56;
  localparam logic [7:0] DEE_KEY2     = 8'hAE;
  localparam logic [7:0] DEE_ERASED   = 8'hFF;
  // timing: default programming cycle time
  localparam int DEE_PROG_US   = 3;
  localparam int DEE_CLK_MHZ   = 200;
  localparam int DEE_PROG_CYC  = DEE_PROG_US * DEE_CLK_MHZ;
  localparam int DEE_ROW_BYTES = 32;
  // controller states
  typedef enum logic [3:0] {
    DEE_IDLE = 4'h1,
    DEE_REQ  = 4'h2,
    DEE_WAIT = 4'h4,
    DEE_DONE = 4'h8
  } dee_mst_t;
endpackage : dee_pkg

// file: rtl/dee_bus_if.sv
// interface: internal memory bus between cpu-side controller and eeprom device
`timescale 1ns/1ps
`default_nettype none
interface dee_bus_if;
  logic        req;     // access strobe, held until ack
  logic        we;      // write when high
  logic [15:0] addr;    // byte address
  logic [7:0]  wdata;   // write data
  logic [7:0]  rdata;   // read data
  logic        rdrive;  // device drives rdata this cycle
  logic        ack;     // one-cycle answer
  logic        wait_req; // wait request (wait instruction or active halt), level
  logic        halt;     // halt request, level
  logic        waiting;  // device in wait state
  modport dev (input req, we, addr, wdata, wait_req, halt,
               output rdata, rdrive, ack, waiting);
  modport cpu (output req, we, addr, wdata, wait_req, halt,
               input rdata, rdrive, ack, waiting);
endinterface : dee_bus_if
`default_nettype wire

// file: rtl/dee_cpu_end.sv
// cpu side: wishbone slave whose orders become memory bus accesses
`timescale 1ns/1ps
`default_nettype none
module dee_cpu_end
  import dee_pkg::*;
(
  // clock and reset
  input  wire logic REF_CLK,
  input  wire logic ARST_N,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [15:0] ADR_I,
  input  wire logic [7:0]  DAT_I,
  input  wire logic        SEL_I,
  output logic [7:0]       DAT_O,
  output logic             ACK_O,
  // power requests
  input  wire logic        WAIT_REQ,
  input  wire logic        HALT_REQ,
  // memory bus
  dee_bus_if.cpu           BUS
);
  dee_mst_t    st_r;       // access state
  logic        req_r;      // bus request
  logic        we_r;       // bus direction
  logic        wait_req_r; // wait request onto the bus
  logic        halt_r;     // halt request onto the bus
  logic        ack_r;      // wishbone answer
  logic [15:0] adr_r;      // held address
  logic [7:0]  wd_r;       // held write data
  logic [7:0]  dat_r;      // read data
  wire start = CYC_I && STB_I && !ack_r && st_r == DEE_IDLE;
  // forward each wishbone cycle as one bus access; undriven reads give ff
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r       <= DEE_IDLE;
      req_r      <= 1'b0;
      we_r       <= 1'b0;
      adr_r      <= 16'h0000;
      wd_r       <= 8'h00;
      dat_r      <= 8'h00;
      ack_r      <= 1'b0;
      wait_req_r <= 1'b0;
      halt_r     <= 1'b0;
    end else begin
      wait_req_r <= WAIT_REQ;
      halt_r     <= HALT_REQ;
      ack_r      <= 1'b0;
      unique case (st_r)
        DEE_IDLE: begin
          if (start) begin
            st_r  <= DEE_REQ;
            req_r <= 1'b1;
            we_r  <= WE_I && SEL_I;
            adr_r <= ADR_I;
            wd_r  <= DAT_I;
          end
        end
        DEE_REQ: begin
          if (BUS.ack) begin
            req_r <= 1'b0;
            dat_r <= BUS.rdrive ? BUS.rdata : DEE_ERASED;
            st_r  <= DEE_DONE;
          end
        end
        DEE_DONE: begin
          ack_r <= 1'b1;
          st_r  <= DEE_WAIT;
        end
        DEE_WAIT: begin
          st_r <= DEE_IDLE;
        end
      endcase
    end
  end
  assign BUS.req      = req_r;
  assign BUS.we       = we_r;
  assign BUS.addr     = adr_r;
  assign BUS.wdata    = wd_r;
  assign BUS.wait_req = wait_req_r;
  assign BUS.halt  = halt_r;
  assign DAT_O     = dat_r;
  assign ACK_O     = ack_r;
endmodule : dee_cpu_end
`default_nettype wire

// file: test/dee_assertions.sv
// checker for the memory bus between the cpu end and the eeprom device
`timescale 1ns/1ps
`default_nettype none
module dee_assertions
  import dee_pkg::*;
(
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        ARST_N,
  // bus signals
  input wire logic        req,
  input wire logic        we,
  input wire logic [15:0] addr,
  input wire logic [7:0]  wdata,
  input wire logic [7:0]  rdata,
  input wire logic        rdrive,
  input wire logic        ack,
  input wire logic        wait_req,
  input wire logic        halt,
  input wire logic        waiting
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  wire area = addr[15:7] == DEE_AREA_BASE[15:7]; // eeprom window hit
  wire csr  = addr == DEE_CTRL_ADDR;             // control register hit
  logic latch_seen_r; // latch mode as last seen on the bus; hardware clears show on next poll
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N)
      latch_seen_r <= 1'b0;
    else if (ack && csr)
      latch_seen_r <= we ? wdata[1] : rdata[1];
  end
  ack_follows_req_a:
    assert property (req && !ack && !wait_req && !halt && !waiting |-> ##[1:3] ack)
    else $error("request left without answer");
  ack_has_cause_a:
    assert property ($rose(ack) |-> $past(req)) else $error("answer without request");
  ack_one_cycle_a:
    assert property (ack |=> !ack) else $error("answer longer than one cycle");
  status_high_zero_a:
    assert property (ack && !we && csr |-> rdata[7:2] == 6'h00) else $error("status top bits set");
  wait_entry_a:
    assert property (wait_req |-> ##[1:24] (waiting || !wait_req))
    else $error("wait state not entered");
  wake_up_a:
    assert property (!wait_req && !halt |-> ##[0:4] !waiting) else $error("wait state kept");
  latched_read_a:
    assert property (ack && !we && area && latch_seen_r |-> !rdrive)
    else $error("driven in latch mode");
  rom_read_a:
    assert property (ack && !we && area && !latch_seen_r |-> rdrive)
    else $error("read not driven");
  cover property (ack && we && csr && wdata[0]);
  cover property (waiting);
  cover property (ack && !we && area && latch_seen_r);
endmodule : dee_assertions
`default_nettype wire

// file: test/data_eeprom_row_programmer_bench.sv
// self-checking bench joining the cpu end and the eeprom device
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_row_programmer_bench
  import dee_pkg::*;
;
  logic        REF_CLK = 1'b0; // system clock
  logic        ARST_N  = 1'b0; // async reset
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, wait_req = 1'b0, halt = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [7:0]  dat = 8'h00, dat_o, rd;
  logic        ack_o, busy, erasing;
  logic [8:0]  notes[$];   // bit 8 set: compare against low byte
  logic [7:0]  mem[0:127]; // expected cell contents
  int          n_mismatch = 0, compares = 0, seed = 15301, k, n_erase = 0;
  always #2.5 REF_CLK = ~REF_CLK;
  dee_bus_if dee_bus_if_inst ();
  // starts read-out protected so that removing it erases the window to a known state
  dee_device #(.PROG_CYC(8)) dee_device_inst (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
    .BUS(dee_bus_if_inst), .OPTION_INIT(2'b01), .BUSY(busy), .ERASING(erasing));
  dee_cpu_end dee_cpu_end_inst (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .DAT_I(dat), .SEL_I(1'b1), .DAT_O(dat_o), .ACK_O(ack_o),
    .WAIT_REQ(wait_req), .HALT_REQ(halt), .BUS(dee_bus_if_inst));
  dee_assertions dee_assertions_inst (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
    .req(dee_bus_if_inst.req), .we(dee_bus_if_inst.we), .addr(dee_bus_if_inst.addr),
    .wdata(dee_bus_if_inst.wdata), .rdata(dee_bus_if_inst.rdata),
    .rdrive(dee_bus_if_inst.rdrive), .ack(dee_bus_if_inst.ack),
    .wait_req(dee_bus_if_inst.wait_req), .halt(dee_bus_if_inst.halt),
    .waiting(dee_bus_if_inst.waiting));
  // one comparison; a mismatch is counted and reported
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // one wishbone cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
    int t;
    t = 0;
    @(posedge REF_CLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge REF_CLK);
      t++;
    end while (ack_o !== 1'b1 && t < 50);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (t >= 50) begin
      n_mismatch++;
      close_out();
    end
  endtask : wb
  task automatic rdq(input logic [15:0] a, input logic [7:0] e);
    notes.push_back({1'b1, e});
    wb(1'b0, a, 8'h00);
  endtask : rdq
  // latched write, expectation follows the and of all writes
  task automatic wr(input logic [6:0] c, input logic [7:0] d);
    mem[c] = mem[c] & d;
    wb(1'b1, DEE_AREA_BASE | {9'h000, c}, d);
  endtask : wr
  // status polled until the go bit drops, bounded
  task automatic poll();
    int t;
    t = 0;
    do begin
      notes.push_back(9'h000);
      wb(1'b0, DEE_CTRL_ADDR, 8'h00);
      t++;
    end while (rd[0] !== 1'b0 && t < 40);
    check("go bit after poll", {7'h00, rd[0]}, 8'h00);
  endtask : poll
  // read results checked against the oldest note; erase pulses counted
  always @(posedge REF_CLK) begin : mon
    logic [8:0] n;
    if (erasing === 1'b1)
      n_erase++;
    if (ack_o === 1'b1 && we === 1'b0 && notes.size() > 0) begin
      n = notes.pop_front();
      if (n[8])
        check("read data", dat_o, n[7:0]);
    end
  end
  initial begin
    for (k = 0; k < 128; k++)
      mem[k] = DEE_ERASED;
    repeat (3) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    rdq(DEE_CTRL_ADDR, DEE_CSR_RST);
    rdq(DEE_FLASH_ADDR, DEE_CSR_RST);
    rdq(16'h1005, DEE_ERASED);
    wb(1'b1, DEE_OPTION_ADDR, 8'h00); // protection removed, window erased
    check("erase pulses", n_erase[7:0], 8'h01);
    wb(1'b1, DEE_FLASH_ADDR, DEE_KEY1);
    wb(1'b1, DEE_FLASH_ADDR, DEE_KEY2);
    wb(1'b1, DEE_FLASH_ADDR, 8'h05);
    rdq(DEE_FLASH_ADDR, 8'h05);
    wb(1'b1, 16'h1005, 8'h00); // read mode write, dropped
    rdq(16'h1005, DEE_ERASED);
    wb(1'b1, DEE_CTRL_ADDR, 8'hFF); // go refused without latch mode already set
    rdq(DEE_CTRL_ADDR, 8'h02);
    rdq(16'h1000, DEE_ERASED);
    wb(1'b1, 16'h1002, 8'h00); // latched then thrown away
    wb(1'b1, DEE_CTRL_ADDR, 8'h00);
    rdq(DEE_CTRL_ADDR, 8'h00);
    wb(1'b1, DEE_CTRL_ADDR, 8'h02);
    wr(7'h03, 8'h5A);
    wb(1'b1, DEE_CTRL_ADDR, 8'h03);
    check("busy", {7'h00, busy}, 8'h01);
    wr(7'h03, 8'hF0); // rewrite while the cycle runs
    poll();
    rdq(DEE_CTRL_ADDR, 8'h00);
    for (k = 2; k < 6; k++)
      rdq(DEE_AREA_BASE + k[15:0], mem[k]);
    wb(1'b1, DEE_CTRL_ADDR, 8'h02);
    for (k = 0; k < 32; k++)
      wr(7'h40 + k[6:0], 8'($random(seed)));
    wb(1'b1, DEE_CTRL_ADDR, 8'h03);
    poll();
    for (k = 0; k < 32; k++)
      rdq(DEE_AREA_BASE + 16'h0040 + k[15:0], mem[64 + k]);
    wb(1'b1, DEE_CTRL_ADDR, 8'h02);
    wr(7'h61, 8'h3C);
    wb(1'b1, DEE_CTRL_ADDR, 8'h03);
    wait_req <= 1'b1; // wait request while programming
    for (k = 0; k < 40 && dee_bus_if_inst.waiting !== 1'b1; k++)
      @(posedge REF_CLK);
    check("waiting", {7'h00, dee_bus_if_inst.waiting}, 8'h01);
    check("busy at wait", {7'h00, busy}, 8'h00);
    wait_req <= 1'b0;
    poll();
    rdq(16'h1061, mem[7'h61]);
    wb(1'b1, DEE_CTRL_ADDR, 8'h02);
    wb(1'b1, 16'h1070, 8'h00);
    wb(1'b1, DEE_CTRL_ADDR, 8'h03);
    halt <= 1'b1; // stop in mid cycle
    repeat (4) @(posedge REF_CLK);
    halt <= 1'b0;
    rdq(DEE_CTRL_ADDR, 8'h02);
    wb(1'b1, DEE_CTRL_ADDR, 8'h00);
    wb(1'b1, DEE_OPTION_ADDR, 8'h02);
    wb(1'b1, DEE_OPTION_ADDR, 8'h00);
    rdq(DEE_OPTION_ADDR, 8'h02);
    rdq(16'h0040, 8'h00); // unmapped place
    @(posedge REF_CLK);
    close_out();
  end
endmodule : data_eeprom_row_programmer_bench
`default_nettype wire
